// ---- verilog/sar_adc_control_window_detect.sv ----
// sar converter control with window detector, behind an sfr port
// assumes a comparator output from the analog core, timer 2 overflow pulse
// and a chip standby level, the last two on mclk
//
// Overview of operation
// - sar clock is mclk divided by 1,2,4,8,16 per config bits 7..5
// - start on busy-bit write of one or timer 2 overflow, per mode bits
// - busy reads one for the whole conversion, zero after
// - busy falling edge sets done flag and raises enabled interrupt
// - each finished result lands in the data word register at 0xBF
// - result is input over reference in 256 steps, 0x80 at half
// - track mode clear: track continuously except during conversion
// - track mode set: track 3 sar clocks from start event, then convert
// - tracking shuts down while the chip is in standby
// - window detector compares each result, sets window flag out of band, or in band when the low limit is above the high limit
// - each limit is a word built from high and low byte registers
// - input select: enable bit 5, port bits 4..3, pin bits 2..0
// - with enable set only the selected port pin becomes analog
// - config bits 4..3 read zero and ignore writes
// - gain field decodes to 1,2,4,8,16 or 0.5 for the amplifier
`timescale 1ns/1ps
module sar_adc_control_window_detect (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// special function register port
	input wire sar_adc_pkg::sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// start and power sources
	input wire logic timer2_overflow,
	input wire logic chip_standby,
	// analog core
	input wire logic comparator_in,
	output sar_adc_pkg::analog_out_t ana,
	// interrupt requests
	output logic done_irq,
	output logic window_irq
);
	import sar_adc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] input_select;
		logic [7:0] config_r;
		logic [7:0] result;
		logic [7:0] gt_hi;
		logic [7:0] gt_lo;
		logic [7:0] lt_hi;
		logic [7:0] lt_lo;
		logic track_mode;
		logic window_flag;
		logic done_flag;
		logic busy;
		logic busy_q;
		logic start_hi;
		logic start_lo;
		logic done_ie;
		logic win_ie;
		phase_t phase;
		logic [2:0] bit_idx;
		logic [7:0] trial;
		logic [1:0] track_cnt;
		logic [1:0] settle_cnt;
		logic comp_meta;
		logic comp_sync;
		logic [7:0] rdata;
		analog_out_t ana;
		logic done_irq;
		logic win_irq;
	} ctl_state_t;

	ctl_state_t st;
	ctl_state_t next_st;
	logic sar_tick;
	logic [31:0] pin_hit;
	logic [4:0] pin_index;

	// ---------------------------------------------------------------
	// sar clock
	// ---------------------------------------------------------------
	sar_clock_divider u_divider (
		.mclk(mclk),
		.reset(reset),
		.div_code(st.config_r[CFG_DIV_LSB +: 3]),
		.tick(sar_tick)
	);

	// ---------------------------------------------------------------
	// analog pin select
	// ---------------------------------------------------------------
	assign pin_index = {st.input_select[SEL_PORT_LSB +: 2], st.input_select[SEL_PIN_LSB +: 3]};

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_pin
			assign pin_hit[gi] = st.input_select[SEL_ENABLE_BIT] && (pin_index == 5'(gi));
		end
	endgenerate

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic window_hit(
		input logic [7:0] res,
		input logic [15:0] gt,
		input logic [15:0] lt
	);
		logic [15:0] word;
		word = {res, 8'h00};
		if (lt > gt) begin
			window_hit = (word > gt) && (word < lt);
		end else begin
			window_hit = (word < lt) || (word > gt);
		end
	endfunction : window_hit

	function automatic logic [5:0] gain_decode(input logic [2:0] code);
		// one-hot: x1, x2, x4, x8, x16, x0.5
		case (code)
			3'h0: gain_decode = 6'h01;
			3'h1: gain_decode = 6'h02;
			3'h2: gain_decode = 6'h04;
			3'h3: gain_decode = 6'h08;
			3'h4: gain_decode = 6'h10;
			3'h5: gain_decode = 6'h10;
			default: gain_decode = 6'h20;
		endcase
	endfunction : gain_decode

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic wr_ctl;
	logic sw_start;
	logic start_req;
	logic mode_sw;
	logic mode_timer;
	logic [7:0] code;
	logic finish;

	always_comb begin
		next_st = st;
		code = st.trial;
		finish = 1'b0;

		// comparator synchroniser
		next_st.comp_meta = comparator_in;
		next_st.comp_sync = st.comp_meta;

		// start selection
		wr_ctl = sfr_req.wr && (sfr_req.addr == ADDR_CONTROL);
		sw_start = wr_ctl && sfr_req.wdata[CTL_BUSY];
		mode_sw = !st.start_lo;
		mode_timer = st.start_lo || st.start_hi;
		start_req = (sw_start && mode_sw) || (timer2_overflow && mode_timer);

		// register writes
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				ADDR_INPUT_SELECT: begin
					next_st.input_select = sfr_req.wdata & SEL_WRITE_MASK;
				end
				ADDR_CONFIG: begin
					next_st.config_r = sfr_req.wdata & CFG_WRITE_MASK;
				end
				ADDR_RESULT: begin
					next_st.result = sfr_req.wdata;
				end
				ADDR_HIGH_LIMIT_LOW: begin
					next_st.gt_lo = sfr_req.wdata;
				end
				ADDR_HIGH_LIMIT_HIGH: begin
					next_st.gt_hi = sfr_req.wdata;
				end
				ADDR_LOW_LIMIT_LOW: begin
					next_st.lt_lo = sfr_req.wdata;
				end
				ADDR_LOW_LIMIT_HIGH: begin
					next_st.lt_hi = sfr_req.wdata;
				end
				ADDR_CONTROL: begin
					next_st.track_mode = sfr_req.wdata[CTL_TRACK_MODE];
					next_st.start_hi = sfr_req.wdata[CTL_START_HI];
					next_st.start_lo = sfr_req.wdata[CTL_START_LO];
					next_st.done_ie = sfr_req.wdata[CTL_DONE_IE];
					next_st.win_ie = sfr_req.wdata[CTL_WIN_IE];
					// flags clear on a written zero only
					if (!sfr_req.wdata[CTL_WINDOW_FLAG]) begin
						next_st.window_flag = 1'b0;
					end
					if (!sfr_req.wdata[CTL_DONE_FLAG]) begin
						next_st.done_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// conversion sequence
		case (st.phase)
			PH_IDLE: begin
				if (start_req) begin
					next_st.busy = 1'b1;
					next_st.bit_idx = 3'h7;
					next_st.settle_cnt = 2'h0;
					next_st.track_cnt = 2'h0;
					if (st.track_mode) begin
						next_st.phase = PH_TRACK;
						next_st.trial = 8'h00;
					end else begin
						next_st.phase = PH_CONVERT;
						next_st.trial = 8'h80;
					end
				end
			end
			PH_TRACK: begin
				// new starts are not looked at here
				if (sar_tick) begin
					if (st.track_cnt == TRACK_SAR_CLOCKS - 2'h1) begin
						next_st.phase = PH_CONVERT;
						next_st.trial = 8'h80;
						next_st.settle_cnt = 2'h0;
					end else begin
						next_st.track_cnt = st.track_cnt + 2'h1;
					end
				end
			end
			PH_CONVERT: begin
				if (st.settle_cnt != SETTLE_CYCLES) begin
					next_st.settle_cnt = st.settle_cnt + 2'h1;
				end else if (sar_tick) begin
					// keep the trial bit when input is at or above it
					code[st.bit_idx] = st.comp_sync;
					next_st.trial = code;
					next_st.settle_cnt = 2'h0;
					if (st.bit_idx == 3'h0) begin
						finish = 1'b1;
					end else begin
						next_st.bit_idx = st.bit_idx - 3'h1;
						next_st.trial[st.bit_idx - 3'h1] = 1'b1;
					end
				end
			end
			default: begin
				next_st.phase = PH_IDLE;
				next_st.busy = 1'b0;
			end
		endcase

		// completion: result store and window check
		if (finish) begin
			next_st.phase = PH_IDLE;
			next_st.busy = 1'b0;
			next_st.result = code;
			if (window_hit(code, {st.gt_hi, st.gt_lo}, {st.lt_hi, st.lt_lo})) begin
				next_st.window_flag = 1'b1;
			end
		end

		// done flag on busy falling edge, set beats clear
		next_st.busy_q = st.busy;
		if (st.busy_q && !st.busy) begin
			next_st.done_flag = 1'b1;
		end
		next_st.done_irq = next_st.done_flag && next_st.done_ie;
		next_st.win_irq = next_st.window_flag && next_st.win_ie;

		// read data
		next_st.rdata = 8'h00;
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				ADDR_INPUT_SELECT: next_st.rdata = st.input_select;
				ADDR_CONFIG: next_st.rdata = st.config_r;
				ADDR_RESULT: next_st.rdata = st.result;
				ADDR_HIGH_LIMIT_LOW: next_st.rdata = st.gt_lo;
				ADDR_HIGH_LIMIT_HIGH: next_st.rdata = st.gt_hi;
				ADDR_LOW_LIMIT_LOW: next_st.rdata = st.lt_lo;
				ADDR_LOW_LIMIT_HIGH: next_st.rdata = st.lt_hi;
				ADDR_CONTROL: begin
					next_st.rdata = {st.track_mode, st.window_flag, st.done_flag, st.busy,
						st.start_hi, st.start_lo, st.done_ie, st.win_ie};
				end
				default: next_st.rdata = 8'h00;
			endcase
		end

		// analog outputs
		if (chip_standby) begin
			next_st.ana.track = 1'b0;
		end else if (next_st.track_mode) begin
			next_st.ana.track = (next_st.phase == PH_TRACK);
		end else begin
			next_st.ana.track = !next_st.busy;
		end
		next_st.ana.dac_code = next_st.trial;
		next_st.ana.pin_en = pin_hit;
		next_st.ana.gain_sel = gain_decode(st.config_r[CFG_GAIN_LSB +: 3]);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.input_select <= RST_INPUT_SELECT;
			st.config_r <= RST_CONFIG;
			st.result <= RST_RESULT;
			st.gt_hi <= RST_LIMIT;
			st.gt_lo <= RST_LIMIT;
			st.lt_hi <= RST_LIMIT;
			st.lt_lo <= RST_LIMIT;
			st.phase <= PH_IDLE;
			st.ana.gain_sel <= 6'h01;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sfr_rdata = st.rdata;
	assign ana = st.ana;
	assign done_irq = st.done_irq;
	assign window_irq = st.win_irq;

endmodule : sar_adc_control_window_detect

// ---- verilog/sar_adc_pkg.sv ----
// sar converter control: shared offsets, fields, reset values and types
// assumes an 8-bit special function register port clocked by mclk
package sar_adc_pkg;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_INPUT_SELECT = 8'hBB;
	localparam logic [7:0] ADDR_CONFIG = 8'hBC;
	localparam logic [7:0] ADDR_RESULT = 8'hBF;
	localparam logic [7:0] ADDR_CONTROL = 8'hC0;
	localparam logic [7:0] ADDR_HIGH_LIMIT_LOW = 8'hC4;
	localparam logic [7:0] ADDR_HIGH_LIMIT_HIGH = 8'hC5;
	localparam logic [7:0] ADDR_LOW_LIMIT_LOW = 8'hC6;
	localparam logic [7:0] ADDR_LOW_LIMIT_HIGH = 8'hC7;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h60;
	localparam logic [7:0] RST_RESULT = 8'h00;
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;

	// ---------------------------------------------------------------
	// field positions and write masks
	// ---------------------------------------------------------------
	localparam int unsigned CFG_DIV_LSB = 5;
	localparam int unsigned CFG_GAIN_LSB = 0;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hE7;
	localparam int unsigned SEL_ENABLE_BIT = 5;
	localparam int unsigned SEL_PORT_LSB = 3;
	localparam int unsigned SEL_PIN_LSB = 0;
	localparam logic [7:0] SEL_WRITE_MASK = 8'h3F;
	localparam int unsigned CTL_TRACK_MODE = 7;
	localparam int unsigned CTL_WINDOW_FLAG = 6;
	localparam int unsigned CTL_DONE_FLAG = 5;
	localparam int unsigned CTL_BUSY = 4;
	localparam int unsigned CTL_START_HI = 3;
	localparam int unsigned CTL_START_LO = 2;
	localparam int unsigned CTL_DONE_IE = 1;
	localparam int unsigned CTL_WIN_IE = 0;

	// ---------------------------------------------------------------
	// timing counts
	// ---------------------------------------------------------------
	localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;
	localparam logic [2:0] DIV_CODE_MAX = 3'h4;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic track;
		logic [7:0] dac_code;
		logic [31:0] pin_en;
		logic [5:0] gain_sel;
	} analog_out_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_TRACK,
		PH_CONVERT
	} phase_t;

endpackage : sar_adc_pkg

// ---- verilog/sar_clock_divider.sv ----
// sar conversion clock divider: one mclk-wide tick per sar clock period
// assumes div_code comes from a register on the same clock
`timescale 1ns/1ps
module sar_clock_divider (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// divide select
	input wire logic [2:0] div_code,
	// sar clock tick
	output logic tick
);
	import sar_adc_pkg::*;

	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;
	logic [3:0] limit;

	// ---------------------------------------------------------------
	// divide ratio 1, 2, 4, 8 or 16
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (div_code >= DIV_CODE_MAX) begin
			limit = 4'hF;
		end else begin
			limit = 4'((5'h01 << div_code) - 5'h01);
		end
		if (st.cnt >= limit) begin
			next_st.cnt = 4'h0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 4'h1;
			next_st.tick = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule : sar_clock_divider

// ---- dv/sar_adc_control_window_detect_assertions.sv ----
// checker for the sar converter control block, bound to its ports
// assumes one clock domain, mclk, and an asynchronous active high reset
`timescale 1ns/1ps
module sar_adc_control_window_detect_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire sar_adc_pkg::sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	// start sources, power and analog core
	input wire logic timer2_overflow,
	input wire logic chip_standby,
	input wire logic comparator_in,
	input wire sar_adc_pkg::analog_out_t ana,
	// interrupt requests
	input wire logic done_irq,
	input wire logic window_irq
);
	import sar_adc_pkg::*;
	// --
	// sequences
	// --
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence ctl_wr;
		sfr_req.wr && sfr_req.addr == ADDR_CONTROL;
	endsequence
	sequence sw_start;
		ctl_wr ##0 sfr_req.wdata[7:2] == 6'h04 && ana.track;
	endsequence
	sequence rd_at(a);
		sfr_req.rd && sfr_req.addr == a;
	endsequence
	// --
	// properties
	// --
	a_start_holds: assert property (sw_start |=> !ana.track && ana.dac_code == 8'h80)
		else $error("start did not hold with first trial");
	a_trial_settle: assert property ($changed(ana.dac_code) && !ana.track |=>
		$stable(ana.dac_code) [*3])
		else $error("trial code changed too soon");
	a_cfg_unused: assert property (rd_at(ADDR_CONFIG) |=> sfr_rdata[4:3] == 2'b00)
		else $error("config unused bits set");
	a_sel_unused: assert property (rd_at(ADDR_INPUT_SELECT) |=> sfr_rdata[7:6] == 2'b00)
		else $error("select unused bits set");
	a_unmapped_zero: assert property (sfr_req.rd &&
		!(sfr_req.addr inside {8'hBB, 8'hBC, 8'hBF, 8'hC0, [8'hC4:8'hC7]}) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_gain_one_hot: assert property ($onehot(ana.gain_sel))
		else $error("gain select not one hot");
	a_pin_single: assert property ($onehot0(ana.pin_en))
		else $error("more than one analog pin");
	a_standby_no_track: assert property (chip_standby [*2] |-> !ana.track)
		else $error("tracking in standby");
	a_done_irq_off: assert property (ctl_wr ##0 !sfr_req.wdata[CTL_DONE_IE] |=> !done_irq)
		else $error("done request stayed up");
	a_win_irq_off: assert property (ctl_wr ##0 !sfr_req.wdata[CTL_WIN_IE] |=> !window_irq)
		else $error("window request stayed up");
endmodule : sar_adc_control_window_detect_assertions

bind sar_adc_control_window_detect sar_adc_control_window_detect_assertions chk (.mclk, .reset,
	.sfr_req, .sfr_rdata, .timer2_overflow, .chip_standby, .comparator_in, .ana, .done_irq,
	.window_irq);

// ---- dv/sar_analog_model.sv ----
// behavioural analog core: track and hold plus comparator against the trial code
// assumes vin is the input level in 256 steps of the reference
`timescale 1ns/1ps
module sar_analog_model (
	// clock
	input wire logic mclk,
	// controls from the block and input level
	input wire sar_adc_pkg::analog_out_t ana,
	input wire logic [7:0] vin,
	// comparator decision
	output logic comparator_in
);
	import sar_adc_pkg::*;
	logic [7:0] held = 8'h00;
	always @(posedge mclk) begin
		if (ana.track) begin
			held <= vin;
		end
	end
	assign comparator_in = held >= ana.dac_code;
endmodule : sar_analog_model

// ---- dv/test_sar_adc_control_window_detect.sv ----
// self-checking bench for the sar converter control block
// assumes the analog model closes the comparator loop, mclk at 50 MHz
`timescale 1ns/1ps
module test_sar_adc_control_window_detect;
	import sar_adc_pkg::*;
	logic mclk;
	logic reset = 1'b1;
	sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic timer2_overflow = 1'b0;
	logic chip_standby = 1'b0;
	logic comparator_in;
	analog_out_t ana;
	logic done_irq;
	logic window_irq;
	logic [7:0] vin = 8'h00;
	logic [7:0] d;
	int mismatches = 0, n_tests = 0, cyc = 0, n, ntr, dv;
	logic [7:0] ra [9] = '{8'hBB, 8'hBC, 8'hBF, 8'hC0, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hA0};
	logic [7:0] vv [6] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h55, 8'hAA};
	logic [2:0] cd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	logic [7:0] sm [4] = '{8'h06, 8'h0A, 8'h0E, 8'h1A};
	// gt high, gt low, lt high, input, window flag
	logic [7:0] wt [7][5] = '{'{8'h10, 8'h00, 8'h20, 8'h18, 8'h01},
		'{8'h10, 8'h00, 8'h20, 8'h30, 8'h00}, '{8'h20, 8'h00, 8'h10, 8'h08, 8'h01},
		'{8'h20, 8'h00, 8'h10, 8'h30, 8'h01}, '{8'h20, 8'h00, 8'h10, 8'h18, 8'h00},
		'{8'h1F, 8'hFF, 8'h10, 8'h20, 8'h01}, '{8'h20, 8'h00, 8'h10, 8'h20, 8'h00}};

	// --
	// design, far side, clock and watchdog
	// --
	sar_adc_control_window_detect uut (.mclk, .reset, .sfr_req, .sfr_rdata, .timer2_overflow,
		.chip_standby, .comparator_in, .ana, .done_irq, .window_irq);
	sar_analog_model far_side (.mclk, .ana, .vin, .comparator_in);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			close_out();
		end
	end

	// --
	// tasks
	// --
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task tend(input string s);
		$display("test %s done", s);
	endtask : tend
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		sfr_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge mclk);
		sfr_req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		sfr_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk);
		sfr_req.rd <= 1'b0;
		#1;
		v = sfr_rdata;
	endtask : rd
	task rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a, d);
		chk(d, e);
	endtask : rchk
	task pulse;
		timer2_overflow <= 1'b1;
		@(posedge mclk);
		timer2_overflow <= 1'b0;
	endtask : pulse
	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle
	task conv(input logic [7:0] v, input logic [7:0] ctl, input logic twice);
		vin = v;
		repeat (500) @(posedge mclk);
		wr(ADDR_CONTROL, ctl & 8'hEF);
		if (ctl[4]) begin
			wr(ADDR_CONTROL, ctl);
			if (twice) begin
				wr(ADDR_CONTROL, ctl);
			end
		end else begin
			pulse();
		end
		#1;
		n = 0;
		ntr = int'(ana.track);
		while (done_irq !== 1'b1 && n < 400) begin
			@(posedge mclk);
			#1;
			n++;
			ntr += int'(ana.track);
		end
		rd(ADDR_CONTROL, d);
		chk(d[CTL_DONE_FLAG], 1'b1);
		chk(d[CTL_BUSY], 1'b0);
		rchk(ADDR_RESULT, v);
	endtask : conv

	// --
	// tests
	// --
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			rchk(ra[i], ra[i] == ADDR_CONFIG ? RST_CONFIG : 8'h00);
		end
		chk(ana.gain_sel, 6'h01);
		wr(8'hA0, 8'hFF);
		rchk(8'hA0, 8'h00);
		for (int i = 4; i < 8; i++) begin
			wr(ra[i], ra[i] ^ 8'h5A);
			rchk(ra[i], ra[i] ^ 8'h5A);
		end
		wr(ADDR_LOW_LIMIT_LOW, 8'h00);
		tend("registers");
		wr(ADDR_CONFIG, 8'hFF);
		rchk(ADDR_CONFIG, 8'hE7);
		for (int g = 0; g < 8; g++) begin
			wr(ADDR_CONFIG, 8'(g));
			settle();
			chk(ana.gain_sel, g[2] ? (g[1] ? 6'h20 : 6'h10) : 6'h01 << g[1:0]);
		end
		wr(ADDR_INPUT_SELECT, 8'hFF);
		rchk(ADDR_INPUT_SELECT, 8'h3F);
		wr(ADDR_INPUT_SELECT, 8'h3C);
		settle();
		chk(ana.pin_en, 32'h1000_0000);
		wr(ADDR_INPUT_SELECT, 8'h1C);
		settle();
		chk(ana.pin_en, 32'h0);
		tend("config");
		for (int i = 0; i < 6; i++) begin
			dv = cd[i][2] ? 16 : 1 << cd[i][1:0];
			dv = (dv == 1) ? 0 : (dv > 4 ? dv : 4);
			wr(ADDR_CONFIG, {cd[i], 5'h00});
			conv(vv[i], 8'h12, 1'b0);
			chk(dv == 0 ? n == 33 : n >= 7 * dv + 5 && n <= 8 * dv + 4, 1);
		end
		wr(ADDR_CONFIG, 8'h00);
		conv(8'h66, 8'h12, 1'b1);
		chk(n, 31);
		tend("divider");
		foreach (sm[i]) begin
			conv(8'h40 + 8'(i), sm[i], 1'b0);
			chk(n, 33);
		end
		wr(ADDR_CONTROL, 8'h02);
		pulse();
		wr(ADDR_CONTROL, 8'h26);
		wr(ADDR_CONTROL, 8'h36);
		repeat (100) @(posedge mclk);
		rd(ADDR_CONTROL, d);
		chk(d[5:4], 2'b00);
		tend("starts");
		conv(8'hC3, 8'h86, 1'b0);
		chk(ntr, 3);
		chk(n, 36);
		wr(ADDR_CONTROL, 8'h02);
		chip_standby <= 1'b1;
		settle();
		chk(ana.track, 1'b0);
		@(posedge mclk);
		chip_standby <= 1'b0;
		settle();
		chk(ana.track, 1'b1);
		tend("track");
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_HIGH_LIMIT_HIGH, wt[i][0]);
			wr(ADDR_HIGH_LIMIT_LOW, wt[i][1]);
			wr(ADDR_LOW_LIMIT_HIGH, wt[i][2]);
			conv(wt[i][3], 8'h13, 1'b0);
			rd(ADDR_CONTROL, d);
			chk(d[CTL_WINDOW_FLAG], wt[i][4][0]);
			chk(window_irq, wt[i][4][0]);
		end
		tend("window");
		close_out();
	end
endmodule : test_sar_adc_control_window_detect
